// file: rtl/hpor_regs.sv
// Port ownership, lockout and command registers of the switching hub.
// Assumes the serial slave engine on the same clock hands over only
// accesses from valid block protocols, one byte per strobe.
`timescale 1ns/1ps
`default_nettype none
module hpor_regs
  import hpor_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire hpor_req_t req,
  output logic [7:0] rdata,
  output logic [7:0] portOwnerCode,
  output logic [3:0] portLocked,
  output logic attachReq,
  output logic interfaceSleep,
  output logic softResetPulse
);
  // ****************************************************************
  // State
  // ****************************************************************
  hpor_state_t st;
  hpor_state_t next_st;
  logic [3:0] nib [HPOR_PORTS];
  hpor_owner_t own [HPOR_PORTS];
  logic [7:0] readMux;
  logic [3:0] lockBits;

  assign nib[0] = st.pairA[3:0];
  assign nib[1] = st.pairA[7:4];
  assign nib[2] = st.pairB[3:0];
  assign nib[3] = st.pairB[7:4];
  assign lockBits = st.freeze[4:1];

  genvar gi;
  generate
    for (gi = 0; gi < HPOR_PORTS; gi++) begin : g_port
      hpor_owner_decode u_dec (
        .code(nib[gi]),
        .owner(own[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    case (req.addr)
      HPOR_OFS_PAIR_A: readMux = st.pairA;
      HPOR_OFS_PAIR_B: readMux = st.pairB;
      HPOR_OFS_PAIR_C: readMux = HPOR_RESET_VAL;
      HPOR_OFS_SEVEN: readMux = HPOR_RESET_VAL;
      HPOR_OFS_FREEZE: readMux = st.freeze;
      HPOR_OFS_CMD: begin
        readMux = HPOR_RESET_VAL;
        readMux[HPOR_CMD_SLEEP_BIT] = st.sleepReq;
        readMux[HPOR_CMD_ATTACH_BIT] = st.attach;
      end
      default: readMux = HPOR_RESET_VAL;
    endcase
  end

  // ****************************************************************
  // Write path
  // ****************************************************************
  // A locked nibble keeps its old code; others take the written code
  function automatic logic [7:0] merge_pair(input logic [7:0] old,
                                            input logic [7:0] wr,
                                            input logic [1:0] lk);
    logic [7:0] r;
    r = old;
    if (!lk[0]) begin
      r[3:0] = wr[3:0];
    end
    if (!lk[1]) begin
      r[7:4] = wr[7:4];
    end
    return r;
  endfunction

  always_comb begin
    next_st = st;
    next_st.softResetPulse = 1'b0;
    // Owner codes trail the stored nibbles by one clock
    next_st.ownerCodes = {own[3], own[2], own[1], own[0]};
    if (req.rdStrobe) begin
      next_st.rdata = readMux;
    end
    // Sleep takes effect once the acknowledge of its write is out
    if (st.sleepPending && req.ackDone) begin
      next_st.sleepReq = 1'b1;
      next_st.sleepPending = 1'b0;
    end
    if (req.wrStrobe && !st.sleepReq) begin
      // Ownership and lockout remain writable after attach
      case (req.addr)
        HPOR_OFS_PAIR_A:
          next_st.pairA = merge_pair(st.pairA, req.wdata, lockBits[1:0]);
        HPOR_OFS_PAIR_B:
          next_st.pairB = merge_pair(st.pairB, req.wdata, lockBits[3:2]);
        HPOR_OFS_FREEZE:
          next_st.freeze = req.wdata & HPOR_FREEZE_MASK;
        HPOR_OFS_CMD: begin
          // Bits 7:3 are not stored, so a stray one does no harm
          if (req.wdata[HPOR_CMD_ATTACH_BIT]) begin
            next_st.attach = 1'b1;
          end
          if (req.wdata[HPOR_CMD_SLEEP_BIT]) begin
            next_st.sleepPending = 1'b1;
          end
          if (req.wdata[HPOR_CMD_SOFTRST_BIT]) begin
            next_st.softResetPulse = 1'b1;
            // Ownership and lockout lie above the protected range, so
            // they return to defaults even after attach.
            next_st.pairA = HPOR_RESET_VAL;
            next_st.pairB = HPOR_RESET_VAL;
            next_st.freeze = HPOR_RESET_VAL;
            next_st.rdata = HPOR_RESET_VAL;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata = st.rdata;
  assign portOwnerCode = st.ownerCodes;
  assign portLocked = lockBits;
  assign attachReq = st.attach;
  assign interfaceSleep = st.sleepReq;
  assign softResetPulse = st.softResetPulse;
endmodule
`default_nettype wire

// file: rtl/hpor_pkg.sv
// Constants, layouts and carriers for the port ownership register group.
// Assumes a byte-wide register port driven by the serial slave engine.
// How it works
// - Port 1 owner in first register low nibble
// - Port 2 owner in first register high nibble
// - Reserved owner codes act as host one
// - Port 3 owner in second register low nibble
// - Port 4 owner in second register high nibble
// - Ports five to seven registers read zero
// - Locked port keeps owner, refuses reassignment
// - Lockout bits one to four map ports
// - Sleep bit powers interface down after ack
// - Sleep bit write-once, cleared only by reset
// - Soft reset restores defaults, self-clears
// - Soft reset spares protected registers after attach
// - Attach bit signals attach, protects low range
// - Attach bit write-once, cleared only by reset
// - Ownership and lockout stay writable after attach
// - All registers reset to zero
// - Only valid block protocols touch registers
// - Undefined addresses read zero, writes ignored
package hpor_pkg;
  localparam logic [7:0] HPOR_OFS_PAIR_A = 8'hF1;
  localparam logic [7:0] HPOR_OFS_PAIR_B = 8'hF2;
  localparam logic [7:0] HPOR_OFS_PAIR_C = 8'hF3;
  localparam logic [7:0] HPOR_OFS_SEVEN = 8'hF4;
  localparam logic [7:0] HPOR_OFS_FREEZE = 8'hF5;
  localparam logic [7:0] HPOR_OFS_CMD = 8'hFF;
  localparam logic [7:0] HPOR_PROTECT_TOP = 8'hF0;
  localparam logic [7:0] HPOR_RESET_VAL = 8'h00;
  localparam logic [7:0] HPOR_FREEZE_MASK = 8'h1E;
  localparam int HPOR_CMD_SLEEP_BIT = 2;
  localparam int HPOR_CMD_SOFTRST_BIT = 1;
  localparam int HPOR_CMD_ATTACH_BIT = 0;
  localparam int HPOR_PORTS = 4;
  localparam logic [3:0] HPOR_OWN_NONE = 4'h0;
  localparam logic [3:0] HPOR_OWN_HOST1 = 4'h1;
  localparam logic [3:0] HPOR_OWN_HOST2 = 4'h2;

  typedef enum logic [1:0] {
    HPOR_UNASSIGNED,
    HPOR_FIRST_HOST,
    HPOR_SECOND_HOST
  } hpor_owner_t;

  // One access from the serial slave engine, valid protocol only
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic ackDone;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpor_req_t;

  typedef struct packed {
    logic [7:0] pairA;
    logic [7:0] pairB;
    logic [7:0] freeze;
    logic sleepReq;
    logic attach;
    logic sleepPending;
    logic [7:0] rdata;
    logic softResetPulse;
    logic [7:0] ownerCodes;
  } hpor_state_t;
endpackage

// file: rtl/hpor_owner_decode.sv
// Decodes one ownership nibble into a host selection.
// Assumes the nibble comes straight from a stored register.
`timescale 1ns/1ps
`default_nettype none
module hpor_owner_decode
  import hpor_pkg::*;
(
  input wire logic [3:0] code,
  output hpor_owner_t owner
);
  always_comb begin
    case (code)
      HPOR_OWN_NONE: owner = HPOR_UNASSIGNED;
      HPOR_OWN_HOST2: owner = HPOR_SECOND_HOST;
      default: owner = HPOR_FIRST_HOST;
    endcase
  end
endmodule
`default_nettype wire

// file: tb/hpor_regs_asserts.sv
// Port-level checks for the ownership register group.
// Assumes binding onto hpor_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hpor_regs_asserts
  import hpor_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire hpor_req_t req,
  input wire logic [7:0] rdata,
  input wire logic [7:0] portOwnerCode,
  input wire logic [3:0] portLocked,
  input wire logic attachReq,
  input wire logic interfaceSleep,
  input wire logic softResetPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wrOk;
  assign wrOk = req.wrStrobe && clkEn && !interfaceSleep;
  function automatic logic [1:0] dec(input logic [3:0] c);
    return (c == 4'h0) ? 2'h0 : (c == 4'h2) ? 2'h2 : 2'h1;
  endfunction
  reset_clear_a: assert property (disable iff (1'b0)
    !nrst && clkEn |=> rdata == 8'h00 && portOwnerCode == 8'h00)
    else $error("not cleared");
  sleep_hold_a: assert property (
    nrst && interfaceSleep |=> interfaceSleep) else $error("sleep lost");
  attach_hold_a: assert property (
    nrst && attachReq |=> attachReq) else $error("attach lost");
  undef_zero_a: assert property (
    req.rdStrobe && clkEn && !(req.addr inside {8'hF1, 8'hF2, 8'hF5,
    8'hFF}) |=> rdata == 8'h00) else $error("undef nonzero");
  owner_map_a: assert property (
    wrOk && req.addr == 8'hF1 && portLocked[1:0] == 2'h0 |-> ##2
    portOwnerCode[3:0] == {dec($past(req.wdata[7:4], 2)),
    dec($past(req.wdata[3:0], 2))}) else $error("owner wrong");
  lock_keep_a: assert property (
    wrOk && req.addr == 8'hF1 && portLocked[0] |-> ##2
    $stable(portOwnerCode[1:0])) else $error("locked moved");
  attach_set_a: assert property (
    wrOk && req.addr == 8'hFF && req.wdata[0] |-> ##[1:2] attachReq)
    else $error("no attach");
  soft_pulse_a: assert property (
    softResetPulse |=> !softResetPulse) else $error("long pulse");
  soft_set_a: assert property (
    wrOk && req.addr == 8'hFF && req.wdata[1] |=> softResetPulse)
    else $error("no soft reset pulse");
  sleep_on_ack_a: assert property (
    nrst && clkEn && !interfaceSleep && !req.ackDone |=> !interfaceSleep)
    else $error("early sleep");
  freeze_hold_a: assert property (
    nrst && !clkEn |=> $stable(portOwnerCode) && $stable(rdata))
    else $error("moved while frozen");
  cover property (interfaceSleep);
  cover property (softResetPulse && attachReq);
  cover property (portLocked[0] && req.wrStrobe);
endmodule
bind hpor_regs hpor_regs_asserts u_chk (.clk, .nrst, .clkEn, .req,
  .rdata, .portOwnerCode, .portLocked, .attachReq, .interfaceSleep,
  .softResetPulse);
`default_nettype wire

// file: tb/hpor_host_model.sv
// Management host model: one register byte per strobe.
// Assumes the group samples requests on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module hpor_host_model
  import hpor_pkg::*;
(
  input wire logic clk,
  output hpor_req_t req
);
  initial req = '0;
  // Released address and data lines carry the inverse and the strobes drop low, so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge clk) req <= '{w, !w, 1'b0, a,
      (a == 8'hFF) ? (d & 8'h07) : d};
    @(posedge clk) req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic ack();
    @(posedge clk) req.ackDone <= 1'b1;
    @(posedge clk) req.ackDone <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the ownership register group.
// Assumes the host model makes every register access.
`timescale 1ns/1ps
`default_nettype none
module tb
  import hpor_pkg::*;
;
  logic clk, nrst, clkEn, attachReq, interfaceSleep, softResetPulse;
  hpor_req_t req;
  logic [7:0] rdata, portOwnerCode;
  logic [3:0] portLocked;
  logic [7:0] a [6] = '{8'hF1, 8'hF2, 8'hF5, 8'hFF, 8'hF3, 8'h10};
  int n_fail = 0;
  int num_checks = 0;
  hpor_regs DUT (.clk, .nrst, .clkEn, .req, .rdata, .portOwnerCode,
    .portLocked, .attachReq, .interfaceSleep, .softResetPulse);
  hpor_host_model host (.clk, .req);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [1:0] dec(input logic [3:0] c);
    return (c == 4'h0) ? 2'h0 : (c == 4'h2) ? 2'h2 : 2'h1;
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, d);
    host.xfer(1'b1, ad, d);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] ad, exp);
    host.xfer(1'b0, ad, 8'h00);
    @(posedge clk);
    #1;
    chk(rdata, exp);
  endtask
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (a[i]) rd(a[i], 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(8'hF1, {c[3:0], 4'h2});
      wr(8'hF2, {4'h0, c[3:0]});
      chk(portOwnerCode, {2'h0, {2{dec(c[3:0])}}, 2'h2});
      rd(8'hF1, {c[3:0], 4'h2});
    end
    wr(8'hF5, 8'hFF);
    rd(8'hF5, 8'h1E);
    wr(8'hF5, 8'h02);
    chk({4'h0, portLocked}, 8'h01);
    wr(8'hF1, 8'h00);
    chk(portOwnerCode, 8'h12);
    for (int i = 4; i < 6; i++) begin
      wr(a[i], 8'h5A);
      rd(a[i], 8'h00);
    end
    wr(8'hF5, 8'h00);
    wr(8'hFF, 8'h01);
    wr(8'hFF, 8'h00);
    rd(8'hFF, 8'h01);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    wr(8'hF1, 8'h21);
    chk(portOwnerCode, 8'h19);
    // A strobe while the clock enable is low must leave everything frozen
    @(posedge clk) clkEn <= 1'b0;
    wr(8'hF1, 8'h12);
    @(posedge clk) clkEn <= 1'b1;
    chk(portOwnerCode, 8'h19);
    rd(8'hF1, 8'h21);
    wr(8'hFF, 8'h03);
    rd(8'hF1, 8'h00);
    rd(8'hFF, 8'h01);
    wr(8'hFF, 8'h05);
    chk({7'h0, interfaceSleep}, 8'h00);
    host.ack();
    wr(8'hFF, 8'h00);
    chk({7'h0, interfaceSleep}, 8'h01);
    wr(8'hF1, 8'h21);
    rd(8'hF1, 8'h00);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    #1;
    chk({6'h0, attachReq, interfaceSleep}, 8'h00);
    wr(8'hF1, 8'h21);
    chk(portOwnerCode, 8'h09);
    report_and_stop();
  end
endmodule
`default_nettype wire
